// File: src/smp_pkg.sv
// Purpose: Constants and carrier types for the serial modem port
// Assumes: 25 MHz system clock, 8N1 character format
// Notes: Register map reached through the documented register port
package smp_pkg;

    // ********************************************
    // Register offsets
    // ********************************************
    localparam logic [3:0] SMP_REG_RATE = 4'h3;     // Rate code
    localparam logic [3:0] SMP_REG_MODEM = 4'h5;    // Modem line control
    localparam logic [3:0] SMP_REG_STATUS = 4'hA;   // Receive error status
    localparam logic [3:0] SMP_REG_DATA = 4'h0;     // Data register

    // Modem line control fields
    localparam int SMP_MC_DTR_BIT = 0;
    localparam int SMP_MC_RTS_BIT = 1;
    localparam int SMP_MC_DRS_BIT = 2;
    localparam logic [7:0] SMP_MODEM_RST = 8'h00;
    localparam logic [2:0] SMP_RATE_RST = 3'h0;     // 300 baud

    // Status fields
    localparam int SMP_ST_PAR_BIT = 0;
    localparam int SMP_ST_FRM_BIT = 1;
    localparam int SMP_ST_OVR_BIT = 2;
    localparam int SMP_ST_BRK_BIT = 3;
    localparam int SMP_ST_RXF_BIT = 6;
    localparam int SMP_ST_PEND_BIT = 7;

    // ********************************************
    // Timing
    // ********************************************
    localparam int SMP_CLK_HZ = 25000000;
    localparam int SMP_OVS = 16;                    // Oversample factor
    localparam int SMP_DATA_BITS = 8;
    localparam logic [3:0] SMP_MID = 4'h7;          // Mid bit tick

    // Per-rate divider to 16x tick
    function automatic logic [12:0] smp_div(input logic [2:0] code);
        int baud;
        case (code)
            3'h0: baud = 300;
            3'h1: baud = 1200;
            3'h2: baud = 2400;
            3'h3: baud = 4800;
            3'h4: baud = 9600;
            default: baud = 19200;
        endcase
        smp_div = 13'(SMP_CLK_HZ / (baud * SMP_OVS));
    endfunction : smp_div

    // Operation commands
    typedef enum logic [1:0] {
        SMP_OP_NONE = 2'h0,
        SMP_OP_TX = 2'h1,
        SMP_OP_RX = 2'h2
    } smp_op_t;

    // Receive error carrier
    typedef struct packed {
        logic brk;
        logic ovr;
        logic frm;
        logic par;
    } smp_err_t;

    // Modem line inputs
    typedef struct packed {
        logic dsr;
        logic cts;
        logic dcd;
    } smp_mdm_in_t;

endpackage : smp_pkg

// File: src/smp_port.sv
// Purpose: Serial modem port with automatic modem line handshaking
// Assumes: Register port with 4-bit address, host ops as commands
// Notes: Line errors come only from the receiver
`timescale 1ns/1ps
`default_nettype none
module smp_port (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Host operations
    input wire smp_pkg::smp_op_t op_i,
    input wire logic op_end_i,
    output logic busy_o,
    output logic tx_ready_o,
    output logic op_done_o,
    output logic err_pend_o,
    // Serial line
    input wire logic rxd_i,
    output logic txd_o,
    // Modem lines
    input wire smp_pkg::smp_mdm_in_t mdm_i,
    output logic dtr_o,
    output logic rts_o,
    output logic drs_o
);
    // ********************************************
    // Declarations
    // ********************************************
    typedef enum logic [4:0] {
        SMP_IDLE = 5'b00001,   // No operation
        SMP_TXW = 5'b00010,    // Waiting on DSR/CTS or data
        SMP_TXS = 5'b00100,    // Shifting a character
        SMP_RXW = 5'b01000,    // Receive in progress
        SMP_DONE = 5'b10000    // Completion pulse
    } smp_st_t;

    smp_st_t st_reg, st_next;
    logic [7:0] modem_reg, modem_next;   // Modem line control
    logic [2:0] rate_reg, rate_next;     // Rate code
    logic [7:0] txbuf_reg, txbuf_next;   // Pending transmit byte
    logic txv_reg, txv_next;             // Pending byte valid
    logic ending_reg, ending_next;       // End of operation queued
    logic [9:0] txsh_reg, txsh_next;     // Frame shifter
    logic [3:0] txn_reg, txn_next;       // Bits left
    logic [3:0] txtk_reg, txtk_next;     // 16x ticks per bit
    logic [7:0] rxbuf_reg, rxbuf_next;   // One-character buffer
    logic rxf_reg, rxf_next;             // Buffer full
    smp_pkg::smp_err_t err_reg, err_next;
    logic pend_reg, pend_next;
    logic dtr_next, rts_next, txd_next, busy_next, done_next;
    logic [7:0] rdata_next;
    logic [12:0] div_reg, div_next;      // Rate divider
    logic tick_reg, tick_next;           // 16x enable pulse
    logic rx_done;
    logic [7:0] rx_data;
    smp_pkg::smp_err_t rx_err;
    logic st_rd;
    logic rx_ok;                         // DSR and DCD both active

    // ********************************************
    // Rate divider
    // ********************************************
    // One-cycle tick at sixteen times the line rate
    always_comb begin
        div_next = div_reg + 13'h1;
        tick_next = 1'b0;
        if (div_reg >= smp_pkg::smp_div(rate_reg) - 13'h1) begin
            div_next = 13'h0;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            div_reg <= 13'h0;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            tick_reg <= tick_next;
        end
    end

    // ********************************************
    // Receiver
    // ********************************************
    smp_rx smp_rx_inst (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .tick_i(tick_reg),
        .rxd_i(rxd_i),
        .done_o(rx_done),
        .data_o(rx_data),
        .err_o(rx_err)
    );

    // ********************************************
    // Registers and receive status
    // ********************************************
    assign st_rd = reg_rd_i && reg_addr_i == smp_pkg::SMP_REG_STATUS;
    // Characters are taken only while DSR and DCD are up
    assign rx_ok = mdm_i.dsr && mdm_i.dcd;

    // Register writes, buffer and error flags
    always_comb begin
        modem_next = modem_reg;
        rate_next = rate_reg;
        txbuf_next = txbuf_reg;
        txv_next = txv_reg;
        rxbuf_next = rxbuf_reg;
        rxf_next = rxf_reg;
        err_next = err_reg;
        pend_next = pend_reg;
        rdata_next = 8'h00;
        // Finished frame frees the buffer; a write in this cycle wins
        if (st_reg == SMP_TXS && txn_reg == 4'h0) txv_next = 1'b0;
        if (reg_wr_i) begin
            case (reg_addr_i)
                smp_pkg::SMP_REG_MODEM: modem_next = reg_wdata_i;
                smp_pkg::SMP_REG_RATE: rate_next = reg_wdata_i[2:0];
                smp_pkg::SMP_REG_DATA: begin
                    txbuf_next = reg_wdata_i;
                    txv_next = 1'b1;
                end
                default: ;
            endcase
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                smp_pkg::SMP_REG_MODEM: rdata_next = modem_reg;
                smp_pkg::SMP_REG_RATE: rdata_next = {5'h00, rate_reg};
                smp_pkg::SMP_REG_DATA: begin
                    rdata_next = rxbuf_reg;
                    rxf_next = 1'b0;
                end
                smp_pkg::SMP_REG_STATUS: rdata_next = {pend_reg, rxf_reg,
                    2'h0, err_reg};
                default: rdata_next = 8'h00;
            endcase
        end
        // Status read clears error bits and pending
        if (st_rd) begin
            err_next = '0;
            pend_next = 1'b0;
        end
        // Only receiver events set error flags; set wins
        if (rx_done && rx_ok) begin
            rxbuf_next = rx_data;
            rxf_next = 1'b1;
            err_next = err_next | rx_err;
            if (rxf_reg && !(reg_rd_i &&
                reg_addr_i == smp_pkg::SMP_REG_DATA))
                err_next.ovr = 1'b1;
            if (|rx_err || rxf_reg) pend_next = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            modem_reg <= smp_pkg::SMP_MODEM_RST;
            rate_reg <= smp_pkg::SMP_RATE_RST;
            txbuf_reg <= 8'h00;
            txv_reg <= 1'b0;
            rxbuf_reg <= 8'h00;
            rxf_reg <= 1'b0;
            err_reg <= '0;
            pend_reg <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            modem_reg <= modem_next;
            rate_reg <= rate_next;
            txbuf_reg <= txbuf_next;
            txv_reg <= txv_next;
            rxbuf_reg <= rxbuf_next;
            rxf_reg <= rxf_next;
            err_reg <= err_next;
            pend_reg <= pend_next;
            reg_rdata_o <= rdata_next;
        end
    end

    // ********************************************
    // Operation sequencer and transmitter
    // ********************************************
    always_comb begin
        st_next = st_reg;
        ending_next = ending_reg;
        txsh_next = txsh_reg;
        txn_next = txn_reg;
        txtk_next = txtk_reg;
        done_next = 1'b0;
        if (op_end_i) ending_next = 1'b1;
        case (st_reg)
            SMP_IDLE: begin
                ending_next = 1'b0;
                if (op_i == smp_pkg::SMP_OP_TX) st_next = SMP_TXW;
                else if (op_i == smp_pkg::SMP_OP_RX) st_next = SMP_RXW;
            end
            SMP_TXW: begin
                // Character goes only with DSR and CTS active
                if (txv_reg && mdm_i.dsr && mdm_i.cts && tick_reg) begin
                    txsh_next = {1'b1, txbuf_reg, 1'b0};
                    txn_next = 4'hA;
                    txtk_next = 4'h0;
                    st_next = SMP_TXS;
                end else if (!txv_reg && ending_reg) begin
                    st_next = SMP_DONE;
                end
            end
            SMP_TXS: begin
                if (txn_reg == 4'h0) st_next = SMP_TXW;
                else if (tick_reg) begin
                    txtk_next = txtk_reg + 4'h1;
                    if (txtk_reg == 4'hF) begin
                        txsh_next = {1'b1, txsh_reg[9:1]};
                        txn_next = txn_reg - 4'h1;
                    end
                end
            end
            SMP_RXW: begin
                // Host ends receive; the buffer keeps what came in
                if (ending_reg) st_next = SMP_DONE;
            end
            SMP_DONE: begin
                done_next = 1'b1;
                st_next = SMP_IDLE;
            end
            default: st_next = SMP_IDLE;
        endcase
    end

    // Modem line drive
    always_comb begin
        // Hold bits force lines active
        dtr_next = modem_reg[smp_pkg::SMP_MC_DTR_BIT];
        rts_next = modem_reg[smp_pkg::SMP_MC_RTS_BIT];
        if (st_next == SMP_TXW || st_next == SMP_TXS) begin
            dtr_next = 1'b1;
            rts_next = 1'b1;
        end else if (st_next == SMP_RXW) begin
            dtr_next = 1'b1;
        end
        // Released again on DONE/IDLE
        txd_next = (st_next == SMP_TXS) ? txsh_next[0] : 1'b1;
        busy_next = st_next != SMP_IDLE;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= SMP_IDLE;
            ending_reg <= 1'b0;
            txsh_reg <= 10'h3FF;
            txn_reg <= 4'h0;
            txtk_reg <= 4'h0;
            dtr_o <= 1'b0;
            rts_o <= 1'b0;
            drs_o <= 1'b0;
            txd_o <= 1'b1;
            busy_o <= 1'b0;
            op_done_o <= 1'b0;
            tx_ready_o <= 1'b0;
            err_pend_o <= 1'b0;
        end else begin
            st_reg <= st_next;
            ending_reg <= ending_next;
            txsh_reg <= txsh_next;
            txn_reg <= txn_next;
            txtk_reg <= txtk_next;
            dtr_o <= dtr_next;
            rts_o <= rts_next;
            drs_o <= modem_next[smp_pkg::SMP_MC_DRS_BIT];
            txd_o <= txd_next;
            busy_o <= busy_next;
            op_done_o <= done_next;
            tx_ready_o <= ~txv_next;
            err_pend_o <= pend_next;
        end
    end

    // ********************************************
    // Assertions
    // ********************************************
    sequence tx_begin_s;
        st_reg == SMP_IDLE && op_i == smp_pkg::SMP_OP_TX;
    endsequence

    tx_lines_up_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        tx_begin_s |=> dtr_o && rts_o)
        else $error("dtr/rts not raised for transmit");
    tx_gate_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        st_reg == SMP_TXW && st_next == SMP_TXS |-> mdm_i.dsr && mdm_i.cts)
        else $error("character sent without dsr/cts");
    tx_release_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        st_reg == SMP_DONE && !modem_reg[smp_pkg::SMP_MC_RTS_BIT] &&
        !modem_reg[smp_pkg::SMP_MC_DTR_BIT] |=> !dtr_o && !rts_o)
        else $error("lines not released after operation");
    rx_lines_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        st_reg == SMP_RXW && $stable(modem_reg) &&
        !modem_reg[smp_pkg::SMP_MC_RTS_BIT] |-> dtr_o && !rts_o)
        else $error("receive line state wrong");
    drs_follow_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> drs_o == $past(modem_next[smp_pkg::SMP_MC_DRS_BIT]))
        else $error("rate select not following control");
    hold_dtr_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        modem_reg[smp_pkg::SMP_MC_DTR_BIT] && $stable(modem_reg) |=> dtr_o)
        else $error("held dtr dropped");
    tx_done_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        st_reg == SMP_TXW && st_next == SMP_DONE |->
        !txv_reg && txn_reg == 4'h0 && txd_o)
        else $error("done before stop bit left");
    err_keep_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        |err_reg && !st_rd |=> |err_reg)
        else $error("error flag lost before status read");
    pend_clr_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        st_rd && !rx_done |=> !pend_reg ##1 !err_pend_o)
        else $error("status read did not clear pending");
    ovr_set_a: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        rx_done && rx_ok && rxf_reg && !reg_rd_i |=> err_reg.ovr)
        else $error("overrun not flagged");

endmodule : smp_port
`default_nettype wire

// File: src/smp_rx.sv
// Purpose: Serial receiver for the modem port, 8N1
// Assumes: Line input synchronous to clk_i, tick_i at 16x rate
// Notes: Reports one character per pulse with its errors
`timescale 1ns/1ps
`default_nettype none
module smp_rx (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Sampling
    input wire logic tick_i,
    input wire logic rxd_i,
    // Character out
    output logic done_o,
    output logic [7:0] data_o,
    output smp_pkg::smp_err_t err_o
);
    // ********************************************
    // Receive state machine
    // ********************************************
    typedef enum logic [3:0] {
        SMP_RX_IDLE = 4'b0001,
        SMP_RX_START = 4'b0010,
        SMP_RX_DATA = 4'b0100,
        SMP_RX_STOP = 4'b1000
    } smp_rx_st_t;

    smp_rx_st_t st_reg, st_next;      // State
    logic [3:0] tk_reg, tk_next;      // Tick counter
    logic [2:0] bit_reg, bit_next;    // Bit index
    logic [7:0] sh_reg, sh_next;      // Shift register
    logic done_next;
    smp_pkg::smp_err_t err_next;

    // Next state
    always_comb begin
        st_next = st_reg;
        tk_next = tk_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        done_next = 1'b0;
        err_next = '0;
        if (tick_i) begin
            tk_next = tk_reg + 4'h1;
            case (st_reg)
                SMP_RX_IDLE: begin
                    tk_next = 4'h0;
                    if (!rxd_i) st_next = SMP_RX_START;
                end
                SMP_RX_START: begin
                    if (tk_reg == smp_pkg::SMP_MID) begin
                        tk_next = 4'h0;
                        // False start is dropped quietly
                        st_next = rxd_i ? SMP_RX_IDLE : SMP_RX_DATA;
                        bit_next = 3'h0;
                    end
                end
                SMP_RX_DATA: begin
                    if (tk_reg == 4'hF) begin
                        sh_next = {rxd_i, sh_reg[7:1]};  // LSB first
                        bit_next = bit_reg + 3'h1;
                        if (bit_reg == 3'h7) st_next = SMP_RX_STOP;
                    end
                end
                SMP_RX_STOP: begin
                    if (tk_reg == 4'hF) begin
                        done_next = 1'b1;
                        st_next = SMP_RX_IDLE;
                        err_next.frm = ~rxd_i;
                        err_next.brk = ~rxd_i && sh_reg == 8'h00;
                        err_next.par = 1'b0;  // No parity bit
                    end
                end
                default: st_next = SMP_RX_IDLE;
            endcase
        end
    end

    // Registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg <= SMP_RX_IDLE;
            tk_reg <= 4'h0;
            bit_reg <= 3'h0;
            sh_reg <= 8'h00;
            done_o <= 1'b0;
            err_o <= '0;
        end else begin
            st_reg <= st_next;
            tk_reg <= tk_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            done_o <= done_next;
            err_o <= err_next;
        end
    end
    assign data_o = sh_reg;

endmodule : smp_rx
`default_nettype wire

// File: tb/smp_peer.sv
// Purpose: Serial peripheral model on the line side of the modem port
// Assumes: 8N1 frames, BIT_CLKS clocks per bit
// Notes: Sends frames only when the bench asks for them
`timescale 1ns/1ps
`default_nettype none
module smp_peer #(
    parameter int BIT_CLKS = 1296 // One bit at the matched rate
) (
    // Clock
    input wire logic clk_i,
    // Line side of the port
    input wire logic txd_i,
    input wire logic dtr_i,
    input wire logic rts_i,
    output logic rxd_o,
    output smp_pkg::smp_mdm_in_t mdm_o
);
    logic [7:0] rx_byte; // Last byte heard with a good stop
    int rx_cnt; // Bytes heard with a good stop
    logic [7:0] sh; // Shift of incoming bits
    int hs_bad; // Frames begun with DTR or RTS low

    // ****************************************
    // Idle line, modem lines inactive
    // ****************************************
    initial begin
        rxd_o = 1'b1;
        mdm_o = '0;
        rx_cnt = 0;
        hs_bad = 0;
        rx_byte = 8'h00;
    end

    // Set modem answer lines after an edge
    task automatic set_lines(input logic dsr, input logic cts,
        input logic dcd);
        @(posedge clk_i);
        mdm_o <= '{dsr, cts, dcd};
    endtask : set_lines

    // One frame, LSB first; a low stop makes a framing error, a break if b is zero
    task automatic send(input logic [7:0] b, input logic stop_ok);
        logic [9:0] fr;
        fr = {stop_ok, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rxd_o <= fr[i];
            repeat (BIT_CLKS - 1) @(posedge clk_i);
        end
        @(posedge clk_i);
        rxd_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i); // Idle gap to resync
    endtask : send

    // Listener: mid-bit sampling of what the port sends
    always begin
        @(negedge txd_i);
        if (dtr_i !== 1'b1 || rts_i !== 1'b1) hs_bad++;
        repeat (BIT_CLKS / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge clk_i);
            sh[i] = txd_i;
        end
        repeat (BIT_CLKS) @(posedge clk_i);
        if (txd_i === 1'b1) begin
            rx_byte = sh;
            rx_cnt++;
        end
    end
endmodule : smp_peer
`default_nettype wire

// File: tb/test_serial_modem_port.sv
// Purpose: Self-checking bench for the serial modem port
// Assumes: 25 MHz clock, rate code 5 (19200 baud)
// Notes: Peer model stands on the line side
`timescale 1ns/1ps
`default_nettype none
module test_serial_modem_port;
    localparam int BIT_CLKS = 1296; // 81 clocks x 16 ticks
    // Design inputs, valued at time zero
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    smp_pkg::smp_op_t op = smp_pkg::SMP_OP_NONE;
    logic op_end = 1'b0;
    // Design outputs and line nets
    logic [7:0] rdata;
    logic busy, tx_ready, done, pend, rxd, txd, dtr, rts, drs;
    smp_pkg::smp_mdm_in_t mdm;
    int err_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] v;

    smp_port smp_port_inst (.clk_i(clk), .rst_n_i(rst_n),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .op_i(op),
        .op_end_i(op_end), .busy_o(busy), .tx_ready_o(tx_ready),
        .op_done_o(done), .err_pend_o(pend), .rxd_i(rxd),
        .txd_o(txd), .mdm_i(mdm), .dtr_o(dtr), .rts_o(rts),
        .drs_o(drs));
    smp_peer #(.BIT_CLKS(BIT_CLKS)) smp_peer_inst (.clk_i(clk),
        .txd_i(txd), .dtr_i(dtr), .rts_i(rts), .rxd_o(rxd),
        .mdm_o(mdm));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            err_count++;
            stop_test();
        end
    end

    // Byte compare, counted
    task automatic chk8(input logic [7:0] g, input logic [7:0] e,
        input string m);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk8
    // Single line compare
    task automatic chk1(input logic g, input logic e, input string m);
        chk8({7'h00, g}, {7'h00, e}, m);
    endtask : chk1
    // Register write, one strobe cycle
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : reg_wr
    // Register read, data one cycle later
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : reg_rd
    // Issue an operation; returns in its first active cycle
    task automatic start_op(input smp_pkg::smp_op_t o);
        @(posedge clk);
        op <= o;
        @(posedge clk);
        op <= smp_pkg::SMP_OP_NONE;
        #1;
    endtask : start_op
    // End an operation and wait, bounded, for its done pulse
    task automatic end_op;
        int n;
        @(posedge clk);
        op_end <= 1'b1;
        @(posedge clk);
        op_end <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 15000) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1(done, 1'b1, "done pulse");
    endtask : end_op

    // Reset values and an unmapped read
    task automatic t_reset;
        chk1(txd, 1'b1, "txd idle");
        chk1(tx_ready, 1'b1, "tx ready idle");
        chk8({busy, dtr, rts, drs}, 8'h00, "lines after reset");
        reg_rd(smp_pkg::SMP_REG_MODEM, v);
        chk8(v, smp_pkg::SMP_MODEM_RST, "modem reset");
        reg_rd(4'hF, v);
        chk8(v, 8'h00, "unmapped read");
    endtask : t_reset
    // Hold bits and rate select line
    task automatic t_modem;
        reg_wr(smp_pkg::SMP_REG_MODEM, 8'h07);
        chk8({drs, rts, dtr}, 8'h07, "all held");
        reg_rd(smp_pkg::SMP_REG_MODEM, v);
        chk8(v, 8'h07, "modem readback");
        reg_wr(smp_pkg::SMP_REG_MODEM, 8'h04);
        chk8({drs, rts, dtr}, 8'h04, "only rate");
        reg_wr(smp_pkg::SMP_REG_MODEM, 8'h00);
        chk1(drs, 1'b0, "rate cleared");
    endtask : t_modem
    // Transmit held off by CTS, then released
    task automatic t_tx;
        reg_wr(smp_pkg::SMP_REG_RATE, 8'h05);
        smp_peer_inst.set_lines(1'b1, 1'b0, 1'b1);
        start_op(smp_pkg::SMP_OP_TX);
        chk8({busy, dtr, rts}, 8'h07, "tx start");
        reg_wr(smp_pkg::SMP_REG_DATA, 8'h3C);
        chk1(tx_ready, 1'b0, "data held");
        repeat (2 * BIT_CLKS) @(posedge clk);
        #1;
        chk1(txd, 1'b1, "held by cts");
        smp_peer_inst.set_lines(1'b1, 1'b1, 1'b1);
        end_op();
        chk8(8'(smp_peer_inst.rx_cnt), 8'h01, "sent before done");
        chk8(smp_peer_inst.rx_byte, 8'h3C, "byte on line");
        chk8({dtr, rts, txd}, 8'h01, "tx end lines");
        chk1(tx_ready, 1'b1, "buffer free");
        chk8(8'(smp_peer_inst.hs_bad), 8'h00, "lines while sending");
        reg_rd(smp_pkg::SMP_REG_STATUS, v);
        chk8(v & 8'h8F, 8'h00, "no tx errors");
    endtask : t_tx
    // Receive, break, overrun, status clear, DTR hold
    task automatic t_rx;
        start_op(smp_pkg::SMP_OP_RX);
        chk8({dtr, rts}, 8'h02, "rx start");
        smp_peer_inst.send(8'hA5, 1'b1);
        chk1(pend, 1'b0, "clean byte");
        reg_rd(smp_pkg::SMP_REG_DATA, v);
        chk8(v, 8'hA5, "rx byte");
        smp_peer_inst.send(8'h00, 1'b0);
        chk1(pend, 1'b1, "break pending");
        smp_peer_inst.send(8'h5A, 1'b1);
        reg_rd(smp_pkg::SMP_REG_STATUS, v);
        chk8(v & 8'h8F, 8'h8E, "error bits");
        @(posedge clk);
        #1;
        chk1(pend, 1'b0, "pend cleared");
        reg_rd(smp_pkg::SMP_REG_STATUS, v);
        chk8(v & 8'h8F, 8'h00, "bits cleared");
        reg_rd(smp_pkg::SMP_REG_DATA, v);
        chk8(v, 8'h5A, "second byte");
        smp_peer_inst.set_lines(1'b1, 1'b1, 1'b0);
        smp_peer_inst.send(8'h33, 1'b1);
        reg_rd(smp_pkg::SMP_REG_STATUS, v);
        chk8(v, 8'h00, "no carrier no char");
        smp_peer_inst.set_lines(1'b1, 1'b1, 1'b1);
        end_op();
        chk8({dtr, rts}, 8'h00, "rx end");
        start_op(smp_pkg::SMP_OP_RX);
        reg_wr(smp_pkg::SMP_REG_MODEM, 8'h01);
        end_op();
        chk1(dtr, 1'b1, "dtr held");
        reg_wr(smp_pkg::SMP_REG_MODEM, 8'h00);
        chk1(dtr, 1'b0, "dtr released");
    endtask : t_rx

    // Counts, verdict, end of run
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        t_reset();
        t_modem();
        t_tx();
        t_rx();
        stop_test();
    end
endmodule : test_serial_modem_port
`default_nettype wire
